/* mmd_regs.svh */
// Address map constants for the memory map decoder
`ifndef MMD_REGS_SVH
`define MMD_REGS_SVH
`define MMD_CODE_FLASH_LO 16'h0000
`define MMD_CODE_FLASH_HI 16'h7FFF
`define MMD_CODE_VEC_HI 16'h00FF
`define MMD_CODE_CTRL_LO 16'h7F00
`define MMD_EXTERNAL_RAM_LO 16'h0000
`define MMD_EXTERNAL_RAM_HI 16'h0EF7
`define MMD_MDU_LO 16'h0EF8
`define MMD_MDU_HI 16'h0FD7
`define MMD_CONV_LO 16'h0FD8
`define MMD_CONV_HI 16'h0FFF
`define MMD_XCR_LO 16'h4020
`define MMD_XCR_HI 16'h40FF
`define MMD_BANK_HI 8'h1F
`define MMD_GPRAM_LO 8'h20
`define MMD_BITRAM_HI 8'h2F
`define MMD_GPRAM_HI 8'h7F
`define MMD_UPPER_LO 8'h80
`endif

/* mmd_pkg.sv */
// Types for the memory map decoder
`default_nettype none
package mmd_pkg;
  typedef enum logic [1:0] {
    MMD_SP_CODE,
    MMD_SP_XDATA,
    MMD_SP_IDIRECT,
    MMD_SP_IINDIRECT
  } mmd_space_t;
  typedef enum logic [2:0] {
    MMD_T_NONE,
    MMD_T_EXTERNAL_RAM,
    MMD_T_MDU,
    MMD_T_CONV,
    MMD_T_XCR
  } mmd_xtgt_t;
endpackage : mmd_pkg
`default_nettype wire

/* mmd_decoder.sv */
// Memory map decoder with 16-bit snapshot read support
// How it works
// - Program and data spaces decode separately by access space code.
// - Program addresses 0x0000..0x7FFF select the flash array.
// - Program addresses up to 0x00FF are flagged as the vector area.
// - Program addresses 0x7F00..0x7FFF are flagged as chip control bits.
// - External data is decoded only on external-data move accesses.
// - External 0x0000..0x0EF7 selects external RAM.
// - External 0x4020..0x40FF selects extended control registers.
// - External 0x0EF8..0x0FD7 selects the multiply/divide unit registers.
// - External 0x0FD8..0x0FFF selects converter results, high/low byte pairs.
// - Internal 0x00..0x1F are four banks of eight working registers.
// - Internal 0x20..0x7F is RAM by direct or indirect access.
// - Internal 0x20..0x2F also supports bit addressing.
// - Indirect 0x80..0xFF goes to upper internal RAM.
// - Direct 0x80..0xFF goes to special function registers.
// - Upper-byte snapshot read captures low byte; next low read returns it.
// - 16-bit values are read as two separate byte reads.
`include "mmd_regs.svh"
`default_nettype none
module mmd_decoder #(
  parameter int SNAP_N = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Core access
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [1:0] acc_space,
  input wire logic [15:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  // Read data returned by targets
  input wire logic [7:0] flash_rdata,
  input wire logic [7:0] external_ram_rdata,
  input wire logic [7:0] mdu_rdata,
  input wire logic [7:0] conv_rdata,
  input wire logic [7:0] xcr_rdata,
  input wire logic [7:0] internal_ram_rdata,
  input wire logic [7:0] sfr_rdata,
  // Live 16-bit snapshot sources and their upper-byte addresses
  input wire logic [SNAP_N*16-1:0] snap_live,
  input wire logic [SNAP_N*16-1:0] snap_addr_hi,
  // Target selects, registered
  output logic flash_sel,
  output logic vector_area,
  output logic ctrl_area,
  output logic external_ram_sel,
  output logic mdu_sel,
  output logic conv_sel,
  output logic xcr_sel,
  output logic work_reg_sel,
  output logic [1:0] work_bank,
  output logic gp_ram_sel,
  output logic bit_area,
  output logic upper_ram_sel,
  output logic sfr_sel,
  output logic tgt_write,
  output logic [15:0] tgt_addr,
  output logic [7:0] tgt_wdata,
  // Read answer
  output logic rd_valid,
  output logic [7:0] rd_data
);

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  wire logic is_code = acc_valid && (acc_space == 2'(mmd_pkg::MMD_SP_CODE));
  wire logic is_x = acc_valid && (acc_space == 2'(mmd_pkg::MMD_SP_XDATA));
  wire logic is_dir = acc_valid && (acc_space == 2'(mmd_pkg::MMD_SP_IDIRECT));
  wire logic is_ind = acc_valid && (acc_space == 2'(mmd_pkg::MMD_SP_IINDIRECT));
  wire logic is_int = is_dir || is_ind;
  wire logic [7:0] ia = acc_addr[7:0];
  wire logic [15:0] ia16 = {8'h00, ia};

  wire logic code_d = is_code && in_rng(acc_addr, `MMD_CODE_FLASH_LO, `MMD_CODE_FLASH_HI);
  wire logic vec_d = code_d && (acc_addr <= `MMD_CODE_VEC_HI);
  wire logic ctl_d = code_d && (acc_addr >= `MMD_CODE_CTRL_LO);
  wire logic external_ram_d = is_x && in_rng(acc_addr, `MMD_EXTERNAL_RAM_LO, `MMD_EXTERNAL_RAM_HI);
  wire logic xcr_d = is_x && in_rng(acc_addr, `MMD_XCR_LO, `MMD_XCR_HI);
  wire logic mdu_d = is_x && in_rng(acc_addr, `MMD_MDU_LO, `MMD_MDU_HI);
  wire logic conv_d = is_x && in_rng(acc_addr, `MMD_CONV_LO, `MMD_CONV_HI);
  wire logic wreg_d = is_int && (ia <= `MMD_BANK_HI);
  // Bank number only means something on a working register access
  wire logic [1:0] bank_d = wreg_d ? ia[4:3] : 2'h0;
  wire logic gp_d = is_int && (ia >= `MMD_GPRAM_LO) && (ia <= `MMD_GPRAM_HI);
  wire logic bit_d = is_int && in_rng(ia16, {8'h00, `MMD_GPRAM_LO},
                                      {8'h00, `MMD_BITRAM_HI});
  wire logic up_d = is_ind && (ia >= `MMD_UPPER_LO);
  wire logic sfr_d = is_dir && (ia >= `MMD_UPPER_LO);
  wire logic any_d = code_d || external_ram_d || xcr_d || mdu_d || conv_d || is_int;
  // Flash is read-only from the core; unmapped external writes are dropped
  wire logic wr_d = acc_write && any_d && !is_code;
  wire logic rd_d = acc_valid && !acc_write;

  // Snapshot matching
  logic [SNAP_N-1:0] hit_hi;
  logic [SNAP_N-1:0] hit_lo;
  logic [SNAP_N*8-1:0] cap_q;
  logic [SNAP_N-1:0] held_q;
  genvar g;
  generate
    for (g = 0; g < SNAP_N; g++) begin : g_snap
      wire logic [15:0] ha = snap_addr_hi[g*16 +: 16];
      assign hit_hi[g] = is_x && rd_d && (acc_addr == ha);
      assign hit_lo[g] = is_x && rd_d && (acc_addr == 16'(ha + 16'h0001));
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          cap_q[g*8 +: 8] <= 8'h00;
          held_q[g] <= 1'b0;
        end else if (hit_hi[g]) begin
          cap_q[g*8 +: 8] <= snap_live[g*16 +: 8];
          held_q[g] <= 1'b1;
        end else if (hit_lo[g]) begin
          held_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  logic snap_lo_hit;
  logic snap_hi_hit;
  logic [7:0] snap_lo_val;
  logic [7:0] snap_hi_val;
  always_comb begin
    snap_lo_hit = 1'b0;
    snap_hi_hit = 1'b0;
    snap_lo_val = 8'h00;
    snap_hi_val = 8'h00;
    for (int i = 0; i < SNAP_N; i++) begin
      if (hit_hi[i]) begin
        snap_hi_hit = 1'b1;
        snap_hi_val = snap_live[i*16+8 +: 8];
      end
      if (hit_lo[i]) begin
        snap_lo_hit = 1'b1;
        snap_lo_val = cap_q[i*8 +: 8];
      end
    end
  end

  wire logic [7:0] mux_d =
    snap_hi_hit ? snap_hi_val :
    snap_lo_hit ? snap_lo_val :
    code_d ? flash_rdata :
    external_ram_d ? external_ram_rdata :
    mdu_d ? mdu_rdata :
    conv_d ? conv_rdata :
    xcr_d ? xcr_rdata :
    sfr_d ? sfr_rdata :
    is_int ? internal_ram_rdata : 8'h00;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flash_sel <= 1'b0;
      vector_area <= 1'b0;
      ctrl_area <= 1'b0;
      external_ram_sel <= 1'b0;
      mdu_sel <= 1'b0;
      conv_sel <= 1'b0;
      xcr_sel <= 1'b0;
      work_reg_sel <= 1'b0;
      work_bank <= 2'h0;
      gp_ram_sel <= 1'b0;
      bit_area <= 1'b0;
      upper_ram_sel <= 1'b0;
      sfr_sel <= 1'b0;
      tgt_write <= 1'b0;
      tgt_addr <= 16'h0000;
      tgt_wdata <= 8'h00;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      flash_sel <= code_d;
      vector_area <= vec_d;
      ctrl_area <= ctl_d;
      external_ram_sel <= external_ram_d;
      mdu_sel <= mdu_d;
      conv_sel <= conv_d;
      xcr_sel <= xcr_d;
      work_reg_sel <= wreg_d;
      work_bank <= bank_d;
      gp_ram_sel <= gp_d;
      bit_area <= bit_d;
      upper_ram_sel <= up_d;
      sfr_sel <= sfr_d;
      tgt_write <= wr_d;
      tgt_addr <= acc_addr;
      tgt_wdata <= acc_wdata;
      rd_valid <= rd_d;
      rd_data <= rd_d ? mux_d : 8'h00;
    end
  end

  wire logic unused_held = ^held_q;

endmodule : mmd_decoder
`default_nettype wire

/* mmd_decoder_chk.sv */
// Port checks for the memory map decoder
`default_nettype none
module mmd_chk (
  // Clock, reset and request
  input wire logic clock, reset_n, acc_valid, acc_write,
  input wire logic [1:0] acc_space,
  input wire logic [15:0] acc_addr,
  // Answer
  input wire logic flash_sel, external_ram_sel, conv_sel, upper_ram_sel, sfr_sel, rd_valid,
  input wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic rq = acc_valid && !acc_write;
  wire logic xq = acc_valid && acc_space == 2'h1;
  chk_read_answer:
    assert property (rq |=> rd_valid) else $error("read unanswered");
  chk_code_flash:
    assert property (rq && acc_space == 2'h0 && !acc_addr[15] |=> flash_sel && !external_ram_sel)
      else $error("code read missed flash");
  chk_direct_sfr:
    assert property (acc_valid && acc_space == 2'h2 && acc_addr[7] |=> sfr_sel && !upper_ram_sel)
      else $error("direct upper not sfr");
  chk_indirect_ram:
    assert property (acc_valid && acc_space == 2'h3 && acc_addr[7] |=> upper_ram_sel && !sfr_sel)
      else $error("indirect upper not ram");
  chk_external_ram_range:
    assert property (xq && acc_addr <= 16'h0EF7 |=> external_ram_sel) else $error("ext ram missed");
  chk_conv_range:
    assert property (xq && acc_addr inside {[16'h0FD8:16'h0FFF]} |=> conv_sel)
      else $error("converter missed");
  chk_space_apart:
    assert property (acc_valid && acc_space != 2'h1 |=> !external_ram_sel && !conv_sel)
      else $error("external select off move");
  chk_unmapped_zero:
    assert property (xq && !acc_write && acc_addr[15] |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
endmodule : mmd_chk
`default_nettype wire

/* mmd_tgt.sv */
// Target read-data model behind the decoder
`default_nettype none
module mmd_tgt (
  // Byte from each target, distinct so a wrong route shows
  output logic [7:0] flash_rdata, external_ram_rdata, mdu_rdata, conv_rdata,
  output logic [7:0] xcr_rdata, internal_ram_rdata, sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  assign {flash_rdata, external_ram_rdata, mdu_rdata, conv_rdata} = 32'h11223344;
  assign {xcr_rdata, internal_ram_rdata, sfr_rdata} = 24'h556677;
endmodule : mmd_tgt
`default_nettype wire

/* memory_map_decoder_tb.sv */
// Self-checking bench for the memory map decoder
`default_nettype none
module memory_map_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, acc_valid, acc_write, tgt_write, rd_valid, flash_sel, vector_area;
  logic ctrl_area, external_ram_sel, mdu_sel, conv_sel, xcr_sel, work_reg_sel, gp_ram_sel, bit_area;
  logic upper_ram_sel, sfr_sel;
  logic [1:0] acc_space, work_bank;
  logic [7:0] acc_wdata, rd_data, flash_rdata, external_ram_rdata, mdu_rdata, conv_rdata;
  logic [7:0] xcr_rdata, internal_ram_rdata, sfr_rdata, tgt_wdata;
  logic [15:0] acc_addr, tgt_addr;
  logic [63:0] snap_live, snap_addr_hi;
  int err_total, checked;
  wire logic [13:0] sel = {flash_sel, vector_area, ctrl_area, external_ram_sel, mdu_sel, conv_sel,
    xcr_sel, work_reg_sel, work_bank, gp_ram_sel, bit_area, upper_ram_sel, sfr_sel};
  mmd_decoder #(.SNAP_N(4)) dut (.clock, .reset_n, .acc_valid, .acc_write, .acc_space,
    .acc_addr, .acc_wdata, .flash_rdata, .external_ram_rdata, .mdu_rdata, .conv_rdata, .xcr_rdata,
    .internal_ram_rdata, .sfr_rdata, .snap_live, .snap_addr_hi, .flash_sel, .vector_area,
    .ctrl_area, .external_ram_sel, .mdu_sel, .conv_sel, .xcr_sel, .work_reg_sel, .work_bank,
    .gp_ram_sel, .bit_area, .upper_ram_sel, .sfr_sel, .tgt_write, .tgt_addr,
    .tgt_wdata, .rd_valid, .rd_data);
  mmd_tgt u_tgt (.flash_rdata, .external_ram_rdata, .mdu_rdata, .conv_rdata, .xcr_rdata,
    .internal_ram_rdata, .sfr_rdata);
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // One access; answer is looked at 1 ns after the clock edge that takes it
  task automatic acc(input logic [1:0] sp, input logic w, input logic [15:0] a,
    input logic [13:0] es, input logic [7:0] ed, input logic we);
    @(posedge clock);
    {acc_valid, acc_write, acc_space, acc_addr} <= {1'b1, w, sp, a};
    @(posedge clock);
    acc_valid <= 1'b0;
    #1;
    cmp("selects", {2'h0, es}, {2'h0, sel});
    cmp("rd_data", {8'h00, ed}, {8'h00, rd_data});
    cmp("strobes", {14'h0, !w, we}, {14'h0, rd_valid, tgt_write});
    cmp("tgt_addr", a, tgt_addr);
    cmp("tgt_wdata", 16'h00C3, {8'h00, tgt_wdata});
  endtask : acc
  task automatic t_code;
    acc(2'h0, 1'b0, 16'h0010, 14'h3000, 8'h11, 1'b0);
    acc(2'h0, 1'b0, 16'h7F00, 14'h2800, 8'h11, 1'b0);
    acc(2'h1, 1'b0, 16'h0010, 14'h0400, 8'h22, 1'b0);
  endtask : t_code
  task automatic t_xdata;
    acc(2'h1, 1'b0, 16'h0EF7, 14'h0400, 8'h22, 1'b0);
    acc(2'h1, 1'b0, 16'h0EF8, 14'h0200, 8'h33, 1'b0);
    acc(2'h1, 1'b0, 16'h0FD8, 14'h0100, 8'h44, 1'b0);
    acc(2'h1, 1'b0, 16'h40FF, 14'h0080, 8'h55, 1'b0);
    acc(2'h1, 1'b0, 16'h8000, 14'h0000, 8'h00, 1'b0);
    acc(2'h1, 1'b1, 16'h8000, 14'h0000, 8'h00, 1'b0);
    acc(2'h1, 1'b1, 16'h0000, 14'h0400, 8'h00, 1'b1);
  endtask : t_xdata
  task automatic t_int;
    acc(2'h2, 1'b0, 16'h001F, 14'h0070, 8'h66, 1'b0);
    acc(2'h2, 1'b0, 16'h0020, 14'h000C, 8'h66, 1'b0);
    acc(2'h3, 1'b0, 16'h0060, 14'h0008, 8'h66, 1'b0);
    acc(2'h2, 1'b0, 16'h00E7, 14'h0001, 8'h77, 1'b0);
    acc(2'h3, 1'b0, 16'h00E7, 14'h0002, 8'h66, 1'b0);
  endtask : t_int
  // Lower byte before any capture, then upper, then lower twice, with the live value moving between
  task automatic t_snap;
    snap_live[15:0] <= 16'hA55A;
    acc(2'h1, 1'b0, 16'h40D9, 14'h0080, 8'h00, 1'b0);
    acc(2'h1, 1'b0, 16'h40D8, 14'h0080, 8'hA5, 1'b0);
    snap_live[15:0] <= 16'h1234;
    acc(2'h1, 1'b0, 16'h40D9, 14'h0080, 8'h5A, 1'b0);
    acc(2'h1, 1'b0, 16'h40D9, 14'h0080, 8'h5A, 1'b0);
  endtask : t_snap
  // Reset in mid-run wins over a live access and clears the capture taken at 0x40DA
  task automatic t_reset;
    snap_live[31:16] <= 16'hBEEF;
    acc(2'h1, 1'b0, 16'h40DA, 14'h0080, 8'hBE, 1'b0);
    @(posedge clock);
    reset_n <= 1'b0;
    {acc_valid, acc_write, acc_space, acc_addr} <= {1'b1, 1'b0, 2'h1, 16'h40DA};
    @(posedge clock);
    {reset_n, acc_valid} <= 2'b10;
    #1;
    cmp("reset_out", 16'h0000, {rd_valid, tgt_write, sel});
    acc(2'h1, 1'b0, 16'h40DB, 14'h0080, 8'h00, 1'b0);
  endtask : t_reset
  task automatic tally_and_finish;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    {reset_n, acc_valid, acc_write, acc_space, acc_addr, snap_live} = '0;
    acc_wdata = 8'hC3;
    snap_addr_hi = {16'h40DE, 16'h40DC, 16'h40DA, 16'h40D8};
    err_total = 0;
    checked = 0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    t_code();
    t_xdata();
    t_int();
    t_snap();
    t_reset();
    tally_and_finish();
  end
endmodule : memory_map_decoder_tb
bind mmd_decoder mmd_chk u_chk (.clock, .reset_n, .acc_valid, .acc_write, .acc_space,
  .acc_addr, .flash_sel, .external_ram_sel, .conv_sel, .upper_ram_sel, .sfr_sel, .rd_valid, .rd_data);
`default_nettype wire
